// *** rtl/i2c_master_defines.vh ***
/*
 Constants for the bus master engine: mode codes, sequencer states,
 bit counts and reset values. Assumes a single clock at the instruction
 rate; included by its bare name from every design file.
*/
`ifndef I2C_MASTER_DEFINES_VH
`define I2C_MASTER_DEFINES_VH

// Mode-select code for master operation
`define MODE_MASTER 4'h8
// Reload field width
`define RELOAD_W 7
// Decrements of the generator per clock (second and fourth quarter)
`define DEC_PER_CLK 7'h02
// Last bit index of a transmitted byte plus acknowledge
`define TX_LAST_BIT 4'h8
// Last bit index of a received byte
`define RX_LAST_BIT 4'h7
// Last bit index of an acknowledge
`define ACK_LAST_BIT 4'h0
// Reset value of the shift register
`define SHIFT_RST 8'h00

// Sequencer states
`define ST_IDLE 4'h0
`define ST_START1 4'h1
`define ST_START2 4'h2
`define ST_RS1 4'h3
`define ST_RS2 4'h4
`define ST_RS3 4'h5
`define ST_BIT_LOW 4'h6
`define ST_BIT_HIGH 4'h7
`define ST_STOP1 4'h8
`define ST_STOP2 4'h9
`define ST_STOP3 4'hA

// Bit engine kinds
`define KIND_TX 2'h0
`define KIND_RX 2'h1
`define KIND_ACK 2'h2

`endif

// *** rtl/bit_rate_counter.v ***
/*
 Baud generator of the bus master: counts a reload value down until it is below two,
 two steps per clock, pulses a rollover and halts until reloaded.
 Assumes the caller loads it for every timed interval.
*/
`timescale 1ns/100ps
`include "i2c_master_defines.vh"

module bit_rate_counter (
	input wire i_clock,
	input wire i_sys_rst,
	input wire i_load,
	input wire i_halt,
	input wire [6:0] i_reload,
	output reg o_rollover
);

	// Remaining count
	reg [6:0] count_reg;
	// Counting in progress
	reg run_reg;

	// Countdown, two decrements per clock, stops once the count is below two
	// reload sets bus rate
	always @(posedge i_clock) begin
		if (i_sys_rst || i_halt) begin
			count_reg <= 7'h00;
			run_reg <= 1'b0;
			o_rollover <= 1'b0;
		end else if (i_load) begin
			// Fresh interval
			count_reg <= i_reload;
			run_reg <= 1'b1;
			o_rollover <= 1'b0;
		end else if (run_reg && count_reg < `DEC_PER_CLK) begin
			run_reg <= 1'b0;
			o_rollover <= 1'b1;
		end else if (run_reg) begin
			count_reg <= count_reg - `DEC_PER_CLK;
			o_rollover <= 1'b0;
		end else begin
			o_rollover <= 1'b0;
		end
	end

endmodule

// *** rtl/i2c_master_engine.v ***
/*
 Bus master engine: Start, Repeated Start, Stop, byte transmit and
 receive, acknowledge, flags, and a two-entry receive buffer.
 Assumes open-drain pads resolved outside and a 10 MHz clock equal to
 the instruction rate.
*/
`timescale 1ns/100ps
`include "i2c_master_defines.vh"

module i2c_master_engine (
	input wire i_clock,
	input wire i_sys_rst,
	input wire [3:0] i_port_mode_select,
	input wire i_port_module_enable,
	input wire [7:0] i_address_baud_reload,
	input wire i_start_req,
	input wire i_rstart_req,
	input wire i_stop_req,
	input wire i_recv_req,
	input wire i_ack_req,
	input wire i_ack_data,
	input wire i_buf_write,
	input wire [7:0] i_buf_data,
	input wire i_irq_clear,
	input wire i_write_collision_flag_clear,
	input wire i_bcol_clear,
	input wire i_rx_ready,
	input wire i_scl_in,
	input wire i_sda_in,
	output reg o_scl_out,
	output reg o_scl_oe,
	output reg o_sda_out,
	output reg o_sda_oe,
	output reg o_serial_irq_flag,
	output reg o_write_collision_flag,
	output reg o_collision_irq_flag,
	output reg o_ack_status_bit,
	output reg o_start_seen,
	output reg o_stop_seen,
	output reg o_start_request_bit,
	output reg o_stop_request_bit,
	output reg o_buffer_full_flag,
	output reg o_busy,
	output reg o_rx_valid,
	output reg [7:0] o_rx_data
);

	// Pin synchronisers and filtered levels
	reg [2:0] scl_sync_reg;
	reg [2:0] sda_sync_reg;
	reg scl_reg;
	reg sda_reg;
	// Sequencer state and bit engine
	reg [3:0] state_reg;
	reg [1:0] kind_reg;
	reg [3:0] bit_reg;
	reg [7:0] shift_reg;
	reg armed_reg;
	reg ack_data_reg;
	reg load_reg;
	// Receive skid entry
	reg skid_valid_reg;
	reg [7:0] skid_data_reg;
	reg push_reg;
	reg [7:0] push_data_reg;
	// Generator rollover
	wire rollover;
	// Master operation selected
	wire master_on;
	// Rollover not shadowed by a pending load
	wire tick;
	// Receive path can take a byte
	wire rx_room;
	// Clock seen high by the filter and the last stage alike
	wire scl_up;

	assign master_on = i_port_module_enable &&
		(i_port_mode_select == `MODE_MASTER);
	assign tick = rollover && !load_reg;
	assign rx_room = !skid_valid_reg;
	// Last stage masks a stale high level right after a short low phase
	assign scl_up = scl_reg && scl_sync_reg[2];

	bit_rate_counter u_rate (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_load(load_reg),
		.i_halt(!master_on),
		.i_reload(i_address_baud_reload[6:0]),
		.o_rollover(rollover)
	);

	// Three-stage pin sampling; change taken when stages two and three agree
	always @(posedge i_clock) begin
		if (i_sys_rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], i_scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], i_sda_in};
			// Accept only settled levels
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_reg <= sda_sync_reg[2];
			end
		end
	end

	// Receive buffer: output entry plus one skid entry
	always @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			skid_valid_reg <= 1'b0;
			skid_data_reg <= 8'h00;
		end else begin
			if (!o_rx_valid || i_rx_ready) begin
				// Output slot free or drained: refill
				if (skid_valid_reg) begin
					o_rx_data <= skid_data_reg;
					o_rx_valid <= 1'b1;
					skid_valid_reg <= push_reg;
					skid_data_reg <= push_data_reg;
				end else begin
					o_rx_valid <= push_reg;
					o_rx_data <= push_data_reg;
				end
			end else if (push_reg) begin
				// Receiver stalled: park the byte
				skid_valid_reg <= 1'b1;
				skid_data_reg <= push_data_reg;
			end
		end
	end

	// Sequencer, pins and flags
	always @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_reg <= `ST_IDLE;
			kind_reg <= `KIND_TX;
			bit_reg <= 4'h0;
			shift_reg <= `SHIFT_RST;
			armed_reg <= 1'b0;
			ack_data_reg <= 1'b0;
			load_reg <= 1'b0;
			push_reg <= 1'b0;
			push_data_reg <= 8'h00;
			o_scl_out <= 1'b0;
			o_sda_out <= 1'b0;
			o_scl_oe <= 1'b0;
			o_sda_oe <= 1'b0;
			o_serial_irq_flag <= 1'b0;
			o_write_collision_flag <= 1'b0;
			o_collision_irq_flag <= 1'b0;
			o_ack_status_bit <= 1'b0;
			o_start_seen <= 1'b0;
			o_stop_seen <= 1'b0;
			o_start_request_bit <= 1'b0;
			o_stop_request_bit <= 1'b0;
			o_buffer_full_flag <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			// Defaults: pulses drop, pins only ever pull low
			load_reg <= 1'b0;
			push_reg <= 1'b0;
			o_scl_out <= 1'b0;
			o_sda_out <= 1'b0;
			// Software clears; a same-cycle set below wins
			if (i_irq_clear) begin
				o_serial_irq_flag <= 1'b0;
			end
			if (i_write_collision_flag_clear) begin
				o_write_collision_flag <= 1'b0;
			end
			if (i_bcol_clear) begin
				o_collision_irq_flag <= 1'b0;
			end
			o_busy <= (state_reg != `ST_IDLE);
			if (!master_on) begin
				// disabled clears start and stop seen
				if (!i_port_module_enable) begin
					o_start_seen <= 1'b0;
					o_stop_seen <= 1'b0;
				end
				state_reg <= `ST_IDLE;
				o_scl_oe <= 1'b0;
				o_sda_oe <= 1'b0;
				o_start_request_bit <= 1'b0;
				o_stop_request_bit <= 1'b0;
				o_buffer_full_flag <= 1'b0;
			end else begin
				case (state_reg)
				`ST_IDLE: begin
					// one request at a time, only here
					if (i_start_req) begin
						o_start_request_bit <= 1'b1;
						if (scl_reg && sda_reg) begin
							load_reg <= 1'b1;
							state_reg <= `ST_START1;
						end else begin
							o_collision_irq_flag <= 1'b1;
							o_start_request_bit <= 1'b0;
						end
					end else if (i_rstart_req) begin
						o_scl_oe <= 1'b1;
						o_sda_oe <= 1'b0;
						load_reg <= 1'b1;
						state_reg <= `ST_RS1;
					end else if (i_stop_req) begin
						o_stop_request_bit <= 1'b1;
						o_scl_oe <= 1'b1;
						o_sda_oe <= 1'b1;
						load_reg <= 1'b1;
						state_reg <= `ST_STOP1;
					end else if (i_buf_write) begin
						// address and direction come from software
						shift_reg <= i_buf_data;
						o_buffer_full_flag <= 1'b1;
						kind_reg <= `KIND_TX;
						bit_reg <= 4'h0;
						o_scl_oe <= 1'b1;
						o_sda_oe <= ~i_buf_data[7];
						load_reg <= 1'b1;
						state_reg <= `ST_BIT_LOW;
					end else if (i_recv_req && rx_room) begin
						kind_reg <= `KIND_RX;
						bit_reg <= 4'h0;
						o_scl_oe <= 1'b1;
						o_sda_oe <= 1'b0;
						load_reg <= 1'b1;
						state_reg <= `ST_BIT_LOW;
					end else if (i_ack_req) begin
						kind_reg <= `KIND_ACK;
						bit_reg <= 4'h0;
						ack_data_reg <= i_ack_data;
						o_scl_oe <= 1'b1;
						o_sda_oe <= ~i_ack_data;
						load_reg <= 1'b1;
						state_reg <= `ST_BIT_LOW;
					end
				end
				`ST_START1: begin
					if (!scl_reg) begin
						o_collision_irq_flag <= 1'b1;
						o_start_request_bit <= 1'b0;
						state_reg <= `ST_IDLE;
					end else if (tick) begin
						o_sda_oe <= 1'b1;
						o_start_seen <= 1'b1;
						o_stop_seen <= 1'b0;
						load_reg <= 1'b1;
						state_reg <= `ST_START2;
					end
				end
				`ST_START2: begin
					if (tick) begin
						o_start_request_bit <= 1'b0;
						o_serial_irq_flag <= 1'b1;
						state_reg <= `ST_IDLE;
					end
				end
				`ST_RS1: begin
					// Data high during clock low, then free clock
					if (tick) begin
						o_scl_oe <= 1'b0;
						armed_reg <= 1'b0;
						state_reg <= `ST_RS2;
					end
				end
				`ST_RS2: begin
					// wait for clock high before timing
					if (!armed_reg && scl_up) begin
						if (!sda_reg) begin
							o_collision_irq_flag <= 1'b1;
							state_reg <= `ST_IDLE;
						end else begin
							armed_reg <= 1'b1;
							load_reg <= 1'b1;
						end
					end else if (armed_reg && tick) begin
						o_sda_oe <= 1'b1;
						o_start_seen <= 1'b1;
						o_stop_seen <= 1'b0;
						load_reg <= 1'b1;
						state_reg <= `ST_RS3;
					end
				end
				`ST_RS3: begin
					if (!scl_reg) begin
						// Another master pulled the clock
						o_collision_irq_flag <= 1'b1;
						state_reg <= `ST_IDLE;
					end else if (tick) begin
						o_serial_irq_flag <= 1'b1;
						state_reg <= `ST_IDLE;
					end
				end
				`ST_BIT_LOW: begin
					// clock low one rollover, then release
					if (tick) begin
						o_scl_oe <= 1'b0;
						armed_reg <= 1'b0;
						state_reg <= `ST_BIT_HIGH;
					end
				end
				`ST_BIT_HIGH: begin
					if (!armed_reg && scl_up) begin
						armed_reg <= 1'b1;
						load_reg <= 1'b1;
					end else if (armed_reg && tick) begin
						// low plus high rollover per bit
						o_scl_oe <= 1'b1;
						case (kind_reg)
						`KIND_TX: begin
							if (bit_reg == `TX_LAST_BIT) begin
								o_ack_status_bit <= sda_reg;
								o_serial_irq_flag <= 1'b1;
								state_reg <= `ST_IDLE;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								bit_reg <= bit_reg + 4'h1;
								if (bit_reg == `RX_LAST_BIT) begin
									// Eighth bit out: free data
									o_buffer_full_flag <= 1'b0;
									o_sda_oe <= 1'b0;
								end else begin
									o_sda_oe <= ~shift_reg[6];
								end
								load_reg <= 1'b1;
								state_reg <= `ST_BIT_LOW;
							end
						end
						`KIND_RX: begin
							shift_reg <= {shift_reg[6:0], sda_reg};
							if (bit_reg == `RX_LAST_BIT) begin
								push_reg <= 1'b1;
								push_data_reg <= {shift_reg[6:0], sda_reg};
								o_serial_irq_flag <= 1'b1;
								state_reg <= `ST_IDLE;
							end else begin
								bit_reg <= bit_reg + 4'h1;
								load_reg <= 1'b1;
								state_reg <= `ST_BIT_LOW;
							end
						end
						default: begin
							o_sda_oe <= ~ack_data_reg;
							o_serial_irq_flag <= 1'b1;
							state_reg <= `ST_IDLE;
						end
						endcase
					end
				end
				`ST_STOP1: begin
					// Release clock with data still low
					if (tick) begin
						o_scl_oe <= 1'b0;
						armed_reg <= 1'b0;
						state_reg <= `ST_STOP2;
					end
				end
				`ST_STOP2: begin
					if (!armed_reg && scl_up) begin
						armed_reg <= 1'b1;
						load_reg <= 1'b1;
					end else if (armed_reg && tick) begin
						o_sda_oe <= 1'b0;
						o_stop_seen <= 1'b1;
						o_start_seen <= 1'b0;
						load_reg <= 1'b1;
						state_reg <= `ST_STOP3;
					end
				end
				`ST_STOP3: begin
					if (tick) begin
						o_stop_request_bit <= 1'b0;
						o_serial_irq_flag <= 1'b1;
						state_reg <= `ST_IDLE;
					end
				end
				default: begin
					state_reg <= `ST_IDLE;
				end
				endcase
				if (i_buf_write && state_reg != `ST_IDLE) begin
					o_write_collision_flag <= 1'b1;
				end
			end
		end
	end

endmodule

// *** verification/i2c_slave_model.sv ***
/* Behavioural bus slave facing the master engine.
   Assumes pull-ups on both lines, sampled on the system clock. */
`timescale 1ns/100ps
module i2c_slave_model (
	input wire i_clock,
	input wire i_scl,
	input wire i_sda,
	input wire i_nack,
	input wire [3:0] i_stretch,
	input wire [7:0] i_byte,
	output logic o_sda_oe,
	output logic o_scl_oe,
	output logic [7:0] o_got
);
	int bits = 0; // Rising clocks since a Start or the last ninth clock
	int hold = 0; // Stretch cycles left
	logic scl_d = 1'b1; // Previous clock level
	logic sda_d = 1'b1; // Previous data level
	logic first = 1'b1; // Address byte phase
	logic rd = 1'b0; // Read direction
	logic ak = 1'b0; // Master acked last byte
	initial o_sda_oe = 1'b0;
	initial o_got = 8'h00;
	// Clock held low while stretching
	assign o_scl_oe = hold != 0;
	// Bus follower
	always @(posedge i_clock) begin
		scl_d <= i_scl;
		sda_d <= i_sda;
		if (hold != 0)
			hold <= hold - 1;
		if (scl_d && i_scl && sda_d && !i_sda) begin
			// Start or repeated Start
			bits <= 0;
			first <= 1'b1;
			rd <= 1'b0;
		end else if (!scl_d && i_scl) begin
			// Rising clock samples a bit
			bits <= bits + 1;
			if (bits < 8)
				o_got <= {o_got[6:0], i_sda};
			if (first && bits == 7)
				rd <= i_sda;
			if (bits == 8)
				ak <= !i_sda;
		end else if (scl_d && !i_scl) begin
			// Falling clock: start the stretch and set data in the same cycle
			hold <= i_stretch;
			if (bits == 8)
				o_sda_oe <= !(rd && !first) && !i_nack;
			else if (bits == 9) begin
				bits <= 0;
				first <= 1'b0;
				o_sda_oe <= rd && ak && !i_byte[7];
			end else
				o_sda_oe <= rd && !first && !i_byte[7 - bits];
		end
	end
endmodule

// *** verification/i2c_master_engine_checker.sv ***
/* Port checker of the bus master engine.
   Bound to every engine instance; one clock domain. */
`timescale 1ns/100ps
`include "i2c_master_defines.vh"
module i2c_master_engine_checker (
	input wire i_clock,
	input wire i_sys_rst,
	input wire [3:0] i_port_mode_select,
	input wire i_port_module_enable,
	input wire i_start_req,
	input wire i_rstart_req,
	input wire i_stop_req,
	input wire i_recv_req,
	input wire i_ack_req,
	input wire i_buf_write,
	input wire i_scl_in,
	input wire o_scl_oe,
	input wire o_sda_oe,
	input wire o_serial_irq_flag,
	input wire o_write_collision_flag,
	input wire o_collision_irq_flag,
	input wire o_start_seen,
	input wire o_stop_seen,
	input wire o_start_request_bit,
	input wire o_stop_request_bit,
	input wire o_buffer_full_flag,
	input wire o_busy
);
	// Master operation selected
	wire mst = i_port_module_enable &&
		i_port_mode_select == `MODE_MASTER;
	// Any request strobe
	wire any_req = i_start_req | i_rstart_req | i_stop_req |
		i_recv_req | i_ack_req | i_buf_write;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	lines_free_a: assert property (
		!i_port_module_enable [*3] |-> !o_scl_oe && !o_sda_oe)
		else $error("lines driven while disabled");
	seen_clear_a: assert property (
		!i_port_module_enable |=> !o_start_seen && !o_stop_seen)
		else $error("seen flags kept while disabled");
	write_collision_flag_start_a: assert property (
		i_buf_write && o_start_request_bit && mst
		|=> o_write_collision_flag) else $error("write not refused");
	write_collision_flag_cause_a: assert property (
		$rose(o_write_collision_flag) |-> $past(i_buf_write))
		else $error("collision flag without write");
	bf_cause_a: assert property (
		$rose(o_buffer_full_flag) |-> $past(i_buf_write) && o_scl_oe)
		else $error("buffer full without write");
	start_done_a: assert property (
		$fell(o_start_request_bit) && mst && !o_collision_irq_flag
		|-> ##[0:2] o_serial_irq_flag) else $error("no start event");
	stop_done_a: assert property (
		$fell(o_stop_request_bit) && mst |-> ##[0:2] o_serial_irq_flag)
		else $error("no stop event");
	clock_hold_a: assert property (
		mst && o_scl_oe && !o_busy && !any_req && !$past(any_req)
		|=> o_scl_oe) else $error("clock released while idle");
	low_phase_a: assert property (
		$rose(o_scl_oe) |-> o_scl_oe [*2])
		else $error("clock low phase too short");
	high_phase_a: assert property (
		$fell(o_scl_oe) |-> !o_scl_oe [*4])
		else $error("clock high phase too short");
	stretch_wait_a: assert property (
		mst && !o_scl_oe && !i_scl_in |=> !o_scl_oe)
		else $error("stretched clock not honoured");
endmodule
bind i2c_master_engine i2c_master_engine_checker chk (.*);

// *** verification/i2c_master_mode_with_baud_gen_test.sv ***
/* Self-checking bench of the bus master engine and a bus slave.
   Assumes pull-ups on both lines and the engine at the clock rate. */
`timescale 1ns/100ps
`include "i2c_master_defines.vh"
module i2c_master_mode_with_baud_gen_test;
	logic clock = 1'b0; // System clock
	logic rst = 1'b1; // Synchronous reset
	logic en = 1'b1; // Module enable
	logic [3:0] mode = `MODE_MASTER; // Mode field
	logic [7:0] rld = 8'h00; // Reload value
	logic [8:0] req = 9'h000; // Request and clear strobes
	logic ack_dat = 1'b0; // Ack level to send
	logic [7:0] wdat = 8'h00; // Byte to send
	logic rx_rdy = 1'b0; // Consumer ready
	logic hold_sda = 1'b0; // Bench holds data low
	logic nack = 1'b0; // Slave refuses
	logic [3:0] strch = 4'h0; // Slave stretch
	logic [7:0] sbyte = 8'h00; // Slave read byte
	logic [6:0] addr; // Slave address
	logic [7:0] q[$]; // Expected received bytes
	int failures = 0;
	int n_compared = 0;
	wire scl_oe, sda_oe, s_scl, s_sda, irq, write_collision_flag, bcol, ackst;
	wire seen_s, seen_p, start_b, stop_b, bf, busy, rx_v;
	wire [7:0] rx_d, got;
	wire pin_c, pin_d; // Pin drive values
	int run = 0; // Cycles of the current clock pull
	logic [7:0] low_len = 8'h00; // Length of the last clock pull
	wire scl = !(scl_oe | s_scl); // Wired clock line
	wire sda = !(sda_oe | s_sda | hold_sda); // Wired data line
	always #50 clock = ~clock;
	// Length of each clock-low pull by the engine
	always @(posedge clock) begin
		if (scl_oe)
			run <= run + 1;
		else if (run != 0) begin
			low_len <= 8'(run);
			run <= 0;
		end
	end
	i2c_master_engine dut (
		.i_clock(clock), .i_sys_rst(rst),
		.i_port_mode_select(mode), .i_port_module_enable(en),
		.i_address_baud_reload(rld), .i_start_req(req[0]),
		.i_rstart_req(req[1]), .i_stop_req(req[2]), .i_recv_req(req[3]),
		.i_ack_req(req[4]), .i_ack_data(ack_dat), .i_buf_write(req[5]),
		.i_buf_data(wdat), .i_irq_clear(req[6]), .i_write_collision_flag_clear(req[7]),
		.i_bcol_clear(req[8]), .i_rx_ready(rx_rdy), .i_scl_in(scl),
		.i_sda_in(sda), .o_scl_out(pin_c), .o_scl_oe(scl_oe),
		.o_sda_out(pin_d),
		.o_sda_oe(sda_oe), .o_serial_irq_flag(irq),
		.o_write_collision_flag(write_collision_flag), .o_collision_irq_flag(bcol),
		.o_ack_status_bit(ackst), .o_start_seen(seen_s),
		.o_stop_seen(seen_p), .o_start_request_bit(start_b),
		.o_stop_request_bit(stop_b), .o_buffer_full_flag(bf),
		.o_busy(busy), .o_rx_valid(rx_v), .o_rx_data(rx_d));
	i2c_slave_model slave (.i_clock(clock), .i_scl(scl), .i_sda(sda),
		.i_nack(nack), .i_stretch(strch), .i_byte(sbyte),
		.o_sda_oe(s_sda), .o_scl_oe(s_scl), .o_got(got));
	// Value comparison
	task automatic check(input logic [7:0] g, input logic [7:0] e,
		input string what);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
		end
	endtask
	// One-cycle strobe on request line k
	task automatic pulse(input int k);
		@(posedge clock);
		req[k] <= 1'b1;
		@(posedge clock);
		req <= 9'h000;
	endtask
	// Bounded wait for the event flag, then clear it
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 1000) begin
			@(posedge clock);
			n++;
		end
		check(irq, 1'b1, "event flag");
		pulse(6);
	endtask
	// Transmit one byte, with a refused stop in mid-byte
	task automatic send(input logic [7:0] b, input logic nk);
		nack <= nk;
		wdat <= b;
		pulse(5);
		repeat (3) @(posedge clock);
		pulse(2);
		@(posedge clock);
		check(stop_b, 1'b0, "stop taken while busy");
		check(bf, 1'b1, "buffer full");
		wait_irq();
		check(got, b, "byte on bus");
		check(ackst, nk, "ack status");
		check(bf, 1'b0, "buffer empty");
		check(low_len, rld[6:0] / 2 + 3, "low phase");
	endtask
	// Ends the run
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog: all tests need a few thousand cycles
	initial begin
		#3000000;
		failures++;
		summarize();
	end
	// Test sequence
	initial begin
		addr = 7'($urandom(32'hbaf6));
		addr = 7'($urandom);
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rld <= {1'($urandom), 7'($urandom % 8)};
		mode <= 4'h1;
		pulse(0);
		repeat (4) @(posedge clock);
		check(busy | sda_oe, 1'b0, "start outside master");
		mode <= `MODE_MASTER;
		$display("test mode done");
		// bus taken with start seen set and a queued write refused
		pulse(0);
		wdat <= 8'h5a;
		pulse(5);
		wait_irq();
		check(seen_s, 1'b1, "start seen");
		check(start_b, 1'b0, "start bit cleared");
		check(write_collision_flag, 1'b1, "queued write refused");
		check(bf, 1'b0, "refused write stored");
		pulse(7);
		$display("test start done");
		send({addr, 1'b0}, 1'b0);
		send(8'($urandom), 1'b1);
		$display("test transmit done");
		pulse(1);
		wait_irq();
		strch <= 4'hc;
		sbyte <= 8'($urandom);
		send({addr, 1'b1}, 1'b0);
		for (int i = 0; i < 2; i++) begin
			pulse(3);
			wait_irq();
			q.push_back(sbyte);
			sbyte <= 8'($urandom);
			ack_dat <= i[0];
			pulse(4);
			wait_irq();
		end
		pulse(3);
		repeat (4) @(posedge clock);
		check(busy, 1'b0, "receive into full buffer");
		while (q.size() > 0) begin
			check(rx_v, 1'b1, "rx valid");
			check(rx_d, q.pop_front(), "rx byte");
			@(posedge clock) rx_rdy <= 1'b1;
			@(posedge clock) rx_rdy <= 1'b0;
			@(posedge clock);
		end
		check(rx_v, 1'b0, "rx drained");
		$display("test receive done");
		pulse(2);
		wait_irq();
		repeat (4) @(posedge clock);
		check(seen_p, 1'b1, "stop seen");
		en <= 1'b0;
		repeat (4) @(posedge clock);
		check(seen_p | seen_s, 1'b0, "seen flags cleared");
		en <= 1'b1;
		$display("test stop done");
		hold_sda <= 1'b1;
		repeat (5) @(posedge clock);
		pulse(0);
		repeat (40) @(posedge clock);
		check(bcol, 1'b1, "bus collision");
		check(irq | seen_s, 1'b0, "aborted start");
		check(pin_c | pin_d, 1'b0, "pins drive only low");
		hold_sda <= 1'b0;
		pulse(8);
		$display("test collision done");
		summarize();
	end
endmodule
